/* inc/io_port_defines.svh */
`ifndef IO_PORT_DEFINES_SVH
`define IO_PORT_DEFINES_SVH

// register indices; byte address is four times the index
`define IDX_PORT0_DATA 7'h00
`define IDX_PORT1_DATA 7'h01
`define IDX_PORT2_DATA 7'h02
`define IDX_PORT3_DATA 7'h03
`define IDX_PORT0_IEN 7'h04
`define IDX_PORT1_IEN 7'h05
`define IDX_PORT2_IEN 7'h06
`define IDX_PORT3_IEN 7'h07
`define IDX_GPIO_CFG 7'h08
`define IDX_SINK_DATA 7'h30
`define IDX_SINK_LVL0 7'h38
`define IDX_SINK_LVL3 7'h3b
`define IDX_SINK_IEN 7'h3c
`define IDX_SINK_POL 7'h3d
`define IDX_INT_STATUS 7'h40
`define IDX_INT_CLEAR 7'h41
`define IDX_INT_ENABLE 7'h42

// field positions
`define CFG_POL_LSB 8
`define INT_GPIO_BIT 0
`define INT_SINK_BIT 1

// reset values
`define RST_GPIO_DATA 32'hffffffff
`define RST_GPIO_CFG 12'h000
`define RST_SINK_DATA 4'hf
`define RST_SINK_LVL 16'h0000

`endif

/* inc/io_port_pkg.sv */
package io_port_pkg;

    typedef enum logic [1:0] {
        mode_input,
        mode_open_drain,
        mode_push_pull,
        mode_spare
    } gpio_mode_e;

    typedef logic [7:0] port_t;
    typedef logic [3:0] sink_t;

endpackage

/* test/io_pin_load.sv */
`timescale 1ns/10ps
module io_pin_load #(parameter int W = 8) (
    input wire logic clk,
    input wire logic [W-1:0] out,
    input wire logic [W-1:0] oe,
    input wire logic [W-1:0] pu,
    input wire logic [W-1:0] low,
    output logic [W-1:0] pin
);
    logic [W-1:0] last = '0;
    // switch to ground wins; a floating pin flips each cycle
    assign pin = ~((oe & ~out) | low) & ((oe & out) | pu | ~last);
    always_ff @(posedge clk) begin
        last <= pin;
    end
endmodule

/* test/io_port_sink_interrupts_tb.sv */
`timescale 1ns/10ps
module io_port_sink_interrupts_tb;
    import io_port_pkg::*;
    logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, gpio_irq_req, sink_irq_req, irq;
    port_t port_zero_pins_in, port_zero_pins_out, port_zero_pins_oe;
    port_t port_one_pins_in, port_one_pins_out, port_one_pins_oe;
    port_t port_two_pins_in, port_two_pins_out, port_two_pins_oe;
    port_t port_three_pins_in, port_three_pins_out, port_three_pins_oe;
    port_t port_zero_pins_pullup_en, port_one_pins_pullup_en;
    port_t port_two_pins_pullup_en, port_three_pins_pullup_en, low1 = '0;
    sink_t sink_port_pins_in, sink_port_pins_sink_en, slow = '0;
    sink_t sink_port_pins_pullup_en;
    logic [15:0] sink_level;
    int fails = 0, checks = 0, greqs = 0, sreqs = 0;
    io_port_sink_interrupts dut (.*);
    io_pin_load #(.W(32)) gp (.clk(pclk),
        .out({port_three_pins_out, port_two_pins_out, port_one_pins_out,
            port_zero_pins_out}),
        .oe({port_three_pins_oe, port_two_pins_oe, port_one_pins_oe,
            port_zero_pins_oe}),
        .pu({port_three_pins_pullup_en, port_two_pins_pullup_en,
            port_one_pins_pullup_en, port_zero_pins_pullup_en}),
        .low({16'h0, low1, 8'h0}),
        .pin({port_three_pins_in, port_two_pins_in, port_one_pins_in,
            port_zero_pins_in}));
    io_pin_load #(.W(4)) sp (.clk(pclk), .out(4'h0),
        .oe(sink_port_pins_sink_en), .pu(sink_port_pins_pullup_en),
        .low(slow), .pin(sink_port_pins_in));
    always #10 pclk = ~pclk;
    always @(negedge pclk) begin
        greqs += (gpio_irq_req === 1'b1);
        sreqs += (sink_irq_req === 1'b1);
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        // answer is taken at the edge that samples pready high
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        if (n >= 50) fails++;
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x,
        input logic xe = 1'b0);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, '0, r, e);
        chk(r, x);
        chk(32'(e), 32'(xe));
    endtask
    task automatic drv(input port_t g, input sink_t s);
        @(posedge pclk);
        low1 <= g;
        slow <= s;
        repeat (3) @(posedge pclk);
    endtask
    task automatic t_regs();
        rd(12'h000, 32'hff);
        rd(12'h0c0, 32'hf);
        rd(12'h0e0, 32'h0);
        wr(12'h010, 32'hff);
        rd(12'h010, 32'h0);
        rd(12'h200, 32'h0, 1'b1);
        rd(12'h002, 32'h0, 1'b1);
        $display("test regs done");
    endtask
    task automatic t_modes();
        for (int p = 0; p < 4; p++) wr(12'(4 * p), 32'ha5);
        wr(12'h020, 32'ha4); // input, open-drain, push-pull, push-pull
        repeat (2) @(negedge pclk);
        chk(port_zero_pins_oe, 32'h0);
        chk(port_one_pins_oe, 32'h5a);
        chk(port_two_pins_out, 32'ha5);
        chk(port_three_pins_pullup_en, 32'h0);
        for (int p = 0; p < 4; p++) rd(12'(4 * p), p ? 32'ha5 : 32'hff);
        wr(12'h020, 32'he4); // port three on the spare code
        repeat (2) @(negedge pclk);
        chk(port_three_pins_oe, 32'h0);
        rd(12'h00c, 32'hff);
        $display("test modes done");
    endtask
    task automatic t_sink();
        wr(12'h0c0, 32'h5);
        for (int i = 0; i < 4; i++)
            wr(12'h0e0 + 12'(4 * i), 32'(16'h690f >> (4 * i)) & 32'hf);
        repeat (2) @(negedge pclk);
        chk(sink_port_pins_sink_en, 32'ha);
        chk(sink_level, 32'h690f);
        drv(8'h0, 4'h1);
        rd(12'h0c0, 32'h4);
        drv(8'h0, 4'h0);
        $display("test sink done");
    endtask
    task automatic t_irq();
        wr(12'h104, 32'h3);
        wr(12'h108, 32'h3);
        wr(12'h014, 32'h1);
        wr(12'h020, 32'h2a4);
        drv(8'h1, 4'h0);
        rd(12'h100, 32'h0);
        drv(8'h0, 4'h0);
        rd(12'h100, 32'h1);
        chk(irq, 32'h1);
        chk(greqs, 32'h1);
        wr(12'h104, 32'h1);
        drv(8'h4, 4'h0);
        drv(8'h0, 4'h0);
        rd(12'h100, 32'h0);
        wr(12'h020, 32'ha4);
        drv(8'h1, 4'h0);
        rd(12'h100, 32'h1);
        chk(greqs, 32'h2);
        drv(8'h0, 4'h0);
        wr(12'h104, 32'h1);
        wr(12'h0f4, 32'h1);
        wr(12'h0f0, 32'h3);
        drv(8'h0, 4'h1);
        rd(12'h100, 32'h0);
        drv(8'h0, 4'h0);
        rd(12'h100, 32'h2);
        chk(irq, 32'h1);
        chk(sreqs, 32'h1);
        wr(12'h104, 32'h2);
        wr(12'h0c0, 32'h7);
        rd(12'h100, 32'h0);
        wr(12'h0c0, 32'h5);
        rd(12'h100, 32'h2);
        $display("test irq done");
    endtask
    task automatic close_out();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_modes();
        t_sink();
        t_irq();
        ce <= 1'b0;
        repeat (3) @(posedge pclk);
        {ce, presetn} <= 2'b10;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h0c0, 32'hf);
        chk(irq, 32'h0);
        close_out();
    end
    initial begin
        // about 235 cycles of traffic; allow ample margin
        #100us;
        fails++;
        close_out();
    end
endmodule
bind io_port_sink_interrupts io_port_sva chk (.*);

/* test/io_port_sva.sv */
`timescale 1ns/10ps
module io_port_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire io_port_pkg::sink_t sink_port_pins_sink_en,
    input wire io_port_pkg::sink_t sink_port_pins_pullup_en,
    input wire logic [15:0] sink_level,
    input wire logic gpio_irq_req,
    input wire logic sink_irq_req,
    input wire logic irq
);
    import io_port_pkg::*;
    logic wdone;
    // a write lands on the edge that samples pready
    assign wdone = pready && pwrite;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_ready_wait: assert property (
        psel && !penable && ce ##1 psel && penable && ce |=> pready)
        else $error("pready missed its access cycle");
    chk_ready_pulse: assert property (pready && ce |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_rdata_idle: assert property (!pready |-> prdata == '0)
        else $error("prdata not zero outside answer");
    chk_sink_pair: assert property (
        (sink_port_pins_sink_en ^ sink_port_pins_pullup_en) == 4'hf)
        else $error("sink and pull-up not exclusive");
    chk_level_write: assert property (
        $changed(sink_level) |-> $past(wdone) || $past(wdone, 2))
        else $error("sink level moved without a write");
    chk_sink_write: assert property (
        $changed(sink_port_pins_sink_en) |-> $past(wdone) || $past(wdone, 2))
        else $error("sink drive moved without a write");
    chk_irq_cause: assert property ($rose(irq) |-> gpio_irq_req ||
        sink_irq_req || $past(wdone) || $past(wdone, 2))
        else $error("irq rose without a cause");
    chk_ce_freeze: assert property (!ce |=> $stable(sink_level) &&
        $stable(irq) && $stable(pready))
        else $error("state moved while ce low");
endmodule

/* verilog/io_port_sink_interrupts.sv */
// How it works
// - written one disables sink, pull-up raises pin
// - written zero drops pull-up, sinks programmed level
// - one-written sink pin reads pin level
// - per-pin sixteen-step sink level register
// - sink pins request interrupt through per-pin mask
// - sink interrupt edge chosen per pin
// - ports are pull-up input, open-drain, push-pull
// - four eight-bit general ports, thirty-two pins
// - all general pin requests merge into one
// - per-pin mask gates general pin interrupts
// - general pin edge chosen per port
// - edges are rising or falling only
// - sink and general requests are separate sources
// - data registers read/write, port interrupt enables write-only
`timescale 1ns/10ps
`include "io_port_defines.svh"

module io_port_sink_interrupts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire io_port_pkg::port_t port_zero_pins_in,
    output io_port_pkg::port_t port_zero_pins_out,
    output io_port_pkg::port_t port_zero_pins_oe,
    output io_port_pkg::port_t port_zero_pins_pullup_en,
    input wire io_port_pkg::port_t port_one_pins_in,
    output io_port_pkg::port_t port_one_pins_out,
    output io_port_pkg::port_t port_one_pins_oe,
    output io_port_pkg::port_t port_one_pins_pullup_en,
    input wire io_port_pkg::port_t port_two_pins_in,
    output io_port_pkg::port_t port_two_pins_out,
    output io_port_pkg::port_t port_two_pins_oe,
    output io_port_pkg::port_t port_two_pins_pullup_en,
    input wire io_port_pkg::port_t port_three_pins_in,
    output io_port_pkg::port_t port_three_pins_out,
    output io_port_pkg::port_t port_three_pins_oe,
    output io_port_pkg::port_t port_three_pins_pullup_en,
    input wire io_port_pkg::sink_t sink_port_pins_in,
    output io_port_pkg::sink_t sink_port_pins_sink_en,
    output io_port_pkg::sink_t sink_port_pins_pullup_en,
    output logic [15:0] sink_level,
    output logic gpio_irq_req,
    output logic sink_irq_req,
    output logic irq
);
    import io_port_pkg::*;

    function automatic logic [7:0] edge_hit(
        input logic [7:0] prev,
        input logic [7:0] cur,
        input logic [7:0] rise
    );
        edge_hit = (rise & ~prev & cur) | (~rise & prev & ~cur);
    endfunction

    // inclusive index span, used by the read mux and the write decode
    function automatic logic in_span(
        input logic [6:0] at,
        input logic [6:0] lo,
        input logic [6:0] hi
    );
        in_span = (at >= lo) && (at <= hi);
    endfunction

    logic [31:0] gpio_data;
    logic [31:0] gpio_ien;
    logic [31:0] gpio_prev;
    logic [11:0] gpio_cfg;
    logic [3:0] sink_data;
    logic [3:0] sink_ien;
    logic [3:0] sink_pol;
    logic [3:0] sink_prev;
    logic [15:0] sink_lvl;
    logic [1:0] int_status;
    logic [1:0] int_enable;
    logic [31:0] pin_out;
    logic [31:0] pin_oe;
    logic [31:0] pin_pull;
    logic [3:0] sink_en;
    logic [3:0] sink_pull;
    logic [31:0] next_prdata;
    logic next_pslverr;

    wire [6:0] idx = paddr[8:2];
    wire word = (paddr[1:0] == 2'b00);
    wire in_window = (paddr[11:9] == 3'b000);
    wire aligned = word && in_window;
    wire access = psel & penable;
    // first access cycle: the answer is prepared, pready still low
    wire answer = access & ~pready;
    wire done = access & pready;
    wire wr = done & pwrite;
    wire [31:0] gpio_in = {port_three_pins_in, port_two_pins_in,
                           port_one_pins_in, port_zero_pins_in};

    wire [31:0] next_out;
    wire [31:0] next_oe;
    wire [31:0] next_pull;
    wire [31:0] gpio_hit;

    // per-port drive style and edge choice
    genvar p;
    generate
        for (p = 0; p < 4; p++) begin : g_port
            gpio_mode_e mode;
            wire rise;
            wire [7:0] data_byte;
            wire [7:0] ien_byte;
            assign mode = gpio_mode_e'(gpio_cfg[2*p +: 2]);
            assign rise = gpio_cfg[`CFG_POL_LSB + p];
            assign data_byte = gpio_data[8*p +: 8];
            assign ien_byte = gpio_ien[8*p +: 8];
            // the spare mode code falls through to input
            assign next_oe[8*p +: 8] =
                (mode == mode_push_pull) ? 8'hff :
                (mode == mode_open_drain) ? ~data_byte : 8'h00;
            assign next_out[8*p +: 8] =
                (mode == mode_push_pull) ? data_byte : 8'h00;
            // push-pull drives both ways, so the pull-up would only waste
            assign next_pull[8*p +: 8] =
                (mode == mode_push_pull) ? 8'h00 : 8'hff;
            assign gpio_hit[8*p +: 8] = ien_byte &
                edge_hit(gpio_prev[8*p +: 8], gpio_in[8*p +: 8], {8{rise}});
        end
    endgenerate

    wire [3:0] next_sink_en;
    wire [3:0] next_sink_pull;
    wire [3:0] sink_rise;
    wire [3:0] sink_fall;
    wire [3:0] sink_hit;

    // per sink pin: drive pair and its own edge choice
    genvar s;
    generate
        for (s = 0; s < 4; s++) begin : g_sink
            wire pin;
            wire was;
            assign pin = sink_port_pins_in[s];
            assign was = sink_prev[s];
            // a one releases the sink so the pull-up lifts the pin
            assign next_sink_en[s] = ~sink_data[s];
            assign next_sink_pull[s] = sink_data[s];
            assign sink_rise[s] = ~was & pin;
            assign sink_fall[s] = was & ~pin;
            assign sink_hit[s] = sink_ien[s] &
                (sink_pol[s] ? sink_rise[s] : sink_fall[s]);
        end
    endgenerate

    wire gpio_event = |gpio_hit;
    wire sink_event = |sink_hit;
    wire [1:0] int_events = {sink_event, gpio_event};

    // one select per register or indexed group; unaligned or unmapped selects nothing
    wire sel_data = aligned &&
        in_span(idx, `IDX_PORT0_DATA, `IDX_PORT3_DATA);
    wire sel_ien = aligned &&
        in_span(idx, `IDX_PORT0_IEN, `IDX_PORT3_IEN);
    wire sel_cfg = aligned && (idx == `IDX_GPIO_CFG);
    wire sel_sink = aligned && (idx == `IDX_SINK_DATA);
    wire sel_lvl = aligned &&
        in_span(idx, `IDX_SINK_LVL0, `IDX_SINK_LVL3);
    wire sel_sink_ien = aligned && (idx == `IDX_SINK_IEN);
    wire sel_pol = aligned && (idx == `IDX_SINK_POL);
    wire sel_status = aligned && (idx == `IDX_INT_STATUS);
    wire sel_clear = aligned && (idx == `IDX_INT_CLEAR);
    wire sel_enable = aligned && (idx == `IDX_INT_ENABLE);
    // status is read-only: a write there is ignored, not refused
    wire sel_any = sel_data | sel_ien | sel_cfg | sel_sink | sel_lvl |
        sel_sink_ien | sel_pol | sel_status | sel_clear | sel_enable;
    wire [1:0] lvl_pin = 2'(idx - `IDX_SINK_LVL0);
    // read-back slices for the addressed port and sink pin
    wire [7:0] pin_byte = gpio_in[8*idx[1:0] +: 8];
    wire [3:0] lvl_byte = sink_lvl[4*lvl_pin +: 4];

    wire [1:0] int_clear = (wr && sel_clear) ? pwdata[1:0] : 2'b00;
    wire [1:0] next_status;

    // a new event wins over a simultaneous clear
    genvar q;
    generate
        for (q = 0; q < 2; q++) begin : g_status
            assign next_status[q] = int_events[q] |
                (int_status[q] & ~int_clear[q]);
        end
    endgenerate
    // level output tracks the enabled sticky bits
    wire [1:0] irq_live = next_status & int_enable;

    always_comb begin
        next_prdata = 32'h0;
        next_pslverr = ~sel_any;
        if (sel_data) begin
            // reads return the level on the pins, not the latch
            next_prdata = {24'h0, pin_byte};
        end else if (sel_ien) begin
            next_prdata = 32'h0;
        end else if (sel_cfg) begin
            next_prdata = {20'h0, gpio_cfg};
        end else if (sel_sink) begin
            next_prdata = {28'h0, sink_port_pins_in};
        end else if (sel_lvl) begin
            next_prdata = {28'h0, lvl_byte};
        end else if (sel_sink_ien) begin
            next_prdata = {28'h0, sink_ien};
        end else if (sel_pol) begin
            next_prdata = {28'h0, sink_pol};
        end else if (sel_status) begin
            next_prdata = {30'h0, int_status};
        end else if (sel_clear) begin
            next_prdata = 32'h0;
        end else if (sel_enable) begin
            next_prdata = {30'h0, int_enable};
        end
    end

    // one wait state: answer is prepared while pready is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= answer;
            prdata <= (answer & ~pwrite) ? next_prdata : 32'h0;
            pslverr <= answer & next_pslverr;
        end
    end

    // writes land only at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpio_data <= `RST_GPIO_DATA;
            gpio_ien <= 32'h0;
            gpio_cfg <= `RST_GPIO_CFG;
        end else if (ce && wr) begin
            if (sel_data) begin
                gpio_data[8*idx[1:0] +: 8] <= pwdata[7:0];
            end else if (sel_ien) begin
                gpio_ien[8*idx[1:0] +: 8] <= pwdata[7:0];
            end else if (sel_cfg) begin
                gpio_cfg <= pwdata[11:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sink_data <= `RST_SINK_DATA;
            sink_lvl <= `RST_SINK_LVL;
            sink_ien <= 4'h0;
            sink_pol <= 4'h0;
            int_enable <= 2'b00;
        end else if (ce && wr) begin
            if (sel_sink) begin
                sink_data <= pwdata[3:0];
            end else if (sel_lvl) begin
                sink_lvl[4*lvl_pin +: 4] <= pwdata[3:0];
            end else if (sel_sink_ien) begin
                sink_ien <= pwdata[3:0];
            end else if (sel_pol) begin
                sink_pol <= pwdata[3:0];
            end else if (sel_enable) begin
                int_enable <= pwdata[1:0];
            end
        end
    end

    // pins are synchronous to pclk, so one sample gives the edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // idle pins are pulled up, so no false edge follows reset
            gpio_prev <= 32'hffffffff;
            sink_prev <= 4'hf;
        end else if (ce) begin
            gpio_prev <= gpio_in;
            sink_prev <= sink_port_pins_in;
        end
    end

    // requests pulse once per cycle that holds an enabled edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= 2'b00;
            gpio_irq_req <= 1'b0;
            sink_irq_req <= 1'b0;
            irq <= 1'b0;
        end else if (ce) begin
            int_status <= next_status;
            gpio_irq_req <= gpio_event;
            sink_irq_req <= sink_event;
            irq <= |irq_live;
        end
    end

    // registered so every pin changes on a clock edge only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= 32'h0;
            pin_oe <= 32'h0;
            pin_pull <= 32'hffffffff;
            sink_en <= 4'h0;
            sink_pull <= 4'hf;
            sink_level <= `RST_SINK_LVL;
        end else if (ce) begin
            pin_out <= next_out;
            pin_oe <= next_oe;
            pin_pull <= next_pull;
            sink_en <= next_sink_en;
            sink_pull <= next_sink_pull;
            sink_level <= sink_lvl;
        end
    end

    // drive, enable and pull-up per port, straight from the pin flops
    assign port_zero_pins_out = pin_out[7:0];
    assign port_one_pins_out = pin_out[15:8];
    assign port_two_pins_out = pin_out[23:16];
    assign port_three_pins_out = pin_out[31:24];

    assign port_zero_pins_oe = pin_oe[7:0];
    assign port_one_pins_oe = pin_oe[15:8];
    assign port_two_pins_oe = pin_oe[23:16];
    assign port_three_pins_oe = pin_oe[31:24];

    assign port_zero_pins_pullup_en = pin_pull[7:0];
    assign port_one_pins_pullup_en = pin_pull[15:8];
    assign port_two_pins_pullup_en = pin_pull[23:16];
    assign port_three_pins_pullup_en = pin_pull[31:24];

    assign sink_port_pins_sink_en = sink_en;
    assign sink_port_pins_pullup_en = sink_pull;

endmodule
